// File: rtl/dbs_pkg.sv
`default_nettype none
package dbs_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] DBS_STATUS_OFS = 8'h21;
    localparam logic [7:0] DBS_TRACE_CTRL_OFS = 8'h22;
    localparam logic [7:0] DBS_TRACE_CTRL_RST = 8'h00;
    localparam logic [7:0] DBS_RDATA_RST = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DBS_FULL_BIT = 7;
    localparam int DBS_SEQ_LSB = 0;
    localparam int DBS_RSV_BIT = 7;
    localparam int DBS_TEN_BIT = 6;
    localparam int DBS_RANGE_LSB = 4;
    localparam int DBS_MODE_LSB = 2;
    localparam int DBS_ALIGN_LSB = 0;

    // ----------------------------------------------------------------
    // Trace buffer size
    // ----------------------------------------------------------------
    localparam logic [6:0] DBS_BUF_LINES = 7'h40;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DBS_ST0 = 3'b000,
        DBS_ST1 = 3'b001,
        DBS_ST2 = 3'b010,
        DBS_ST3 = 3'b011,
        DBS_FINAL = 3'b100
    } dbs_seq_t;

    typedef enum logic [1:0] {
        DBS_MODE_NORMAL = 2'b00,
        DBS_MODE_LOOP = 2'b01,
        DBS_MODE_DETAIL = 2'b10,
        DBS_MODE_PURE_PC = 2'b11
    } dbs_mode_t;

    typedef enum logic [1:0] {
        DBS_RANGE_ALL = 2'b00,
        DBS_RANGE_UPTO_D = 2'b01,
        DBS_RANGE_FROM_C = 2'b10,
        DBS_RANGE_C_TO_D = 2'b11
    } dbs_range_t;

    typedef enum logic [1:0] {
        DBS_ALIGN_END = 2'b00,
        DBS_ALIGN_BEGIN = 2'b01,
        DBS_ALIGN_MID = 2'b10,
        DBS_ALIGN_RSV = 2'b11
    } dbs_align_t;
endpackage
`default_nettype wire

// File: rtl/dbs_sequencer.sv
`default_nettype none
module dbs_sequencer
    import dbs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sys_reset,
    // Session control
    input wire logic armed,
    input wire logic arm_write,
    input wire logic trig_end,
    // State requests
    input wire logic seq_goto_valid,
    input wire logic [2:0] seq_goto_code,
    // Flags
    output var logic [2:0] seq_flags
);
    typedef struct packed {
        dbs_seq_t state;
    } dbs_seq_state_t;

    dbs_seq_state_t r;
    dbs_seq_state_t next_r;

    function automatic logic dbs_code_legal(input logic [2:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            3'b000, 3'b001, 3'b010, 3'b011, 3'b100: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    always_comb begin
        next_r = r;
        if (sys_reset) begin
            next_r.state = DBS_ST0;
        end else if (trig_end) begin
            // Hardware end beats a same-cycle arm write
            next_r.state = DBS_ST0;
        end else if (arm_write) begin
            next_r.state = DBS_ST1;
        end else if (armed && seq_goto_valid && dbs_code_legal(seq_goto_code)) begin
            next_r.state = dbs_seq_t'(seq_goto_code);
        end
        // Software disarm leaves the last state in place
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r <= '{state: DBS_ST0};
        end else begin
            r <= next_r;
        end
    end

    assign seq_flags = r.state;
endmodule
`default_nettype wire

// File: rtl/dbs_range_filter.sv
`default_nettype none
module dbs_range_filter
    import dbs_pkg::*;
#(
    parameter int ADDR_W = 23
) (
    // Address and bounds
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [ADDR_W-1:0] cmp_c_addr,
    input wire logic [ADDR_W-1:0] cmp_d_addr,
    // Selection
    input wire logic [1:0] range_sel,
    output var logic in_range
);
    always_comb begin
        unique case (dbs_range_t'(range_sel))
            DBS_RANGE_ALL: in_range = 1'b1;
            DBS_RANGE_UPTO_D: in_range = (addr <= cmp_d_addr);
            DBS_RANGE_FROM_C: in_range = (addr >= cmp_c_addr);
            DBS_RANGE_C_TO_D: in_range = (addr >= cmp_c_addr) && (addr <= cmp_d_addr);
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/dbs_status_trace.sv
`default_nettype none
module dbs_status_trace
    import dbs_pkg::*;
#(
    parameter int ADDR_W = 23
) (
    // Clock and resets
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sys_reset,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output var logic [7:0] bus_rdata,
    // Session control
    input wire logic armed,
    input wire logic arm_write,
    input wire logic secured,
    input wire logic trig_end,
    input wire logic seq_goto_valid,
    input wire logic [2:0] seq_goto_code,
    // Comparators
    input wire logic [ADDR_W-1:0] cmp_c_addr,
    input wire logic [ADDR_W-1:0] cmp_d_addr,
    input wire logic cmp_c_match,
    input wire logic cmp_d_match,
    input wire logic cmp_c_enable,
    input wire logic cmp_d_enable,
    output var logic cmp_c_trig,
    output var logic cmp_d_trig,
    // Core activity
    input wire logic cof_valid,
    input wire logic [ADDR_W-1:0] cof_addr,
    input wire logic acc_valid,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic pc_valid,
    input wire logic [ADDR_W-1:0] pc_addr,
    // Trace buffer
    input wire logic line_written,
    input wire logic [6:0] entry_count,
    output var logic [6:0] valid_lines,
    output var logic store_cof,
    output var logic store_acc,
    output var logic store_pc,
    output var logic [ADDR_W-1:0] store_addr,
    // Trigger alignment
    output var logic trig_align_end,
    output var logic trig_align_begin,
    output var logic trig_align_mid
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] tctrl;
        logic full;
        logic [6:0] lines;
        logic [7:0] rdata;
        logic [6:0] valid;
        logic s_cof;
        logic s_acc;
        logic s_pc;
        logic [ADDR_W-1:0] s_addr;
        logic [ADDR_W-1:0] last_cof;
        logic have_last;
        logic a_end;
        logic a_begin;
        logic a_mid;
        logic c_trig;
        logic d_trig;
    } dbs_core_t;

    dbs_core_t r;
    dbs_core_t next_r;
    logic [2:0] seq_flags;
    logic acc_in_range;
    logic trace_active;
    dbs_mode_t mode;
    dbs_align_t align;

    // ----------------------------------------------------------------
    // Sequencer and range filter
    // ----------------------------------------------------------------
    dbs_sequencer u_seq (
        .core_clk(core_clk),
        .resetn(resetn),
        .sys_reset(sys_reset),
        .armed(armed),
        .arm_write(arm_write),
        .trig_end(trig_end),
        .seq_goto_valid(seq_goto_valid),
        .seq_goto_code(seq_goto_code),
        .seq_flags(seq_flags)
    );

    dbs_range_filter #(
        .ADDR_W(ADDR_W)
    ) u_range (
        .addr(acc_addr),
        .cmp_c_addr(cmp_c_addr),
        .cmp_d_addr(cmp_d_addr),
        .range_sel(r.tctrl[DBS_RANGE_LSB+:2]),
        .in_range(acc_in_range)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    assign mode = dbs_mode_t'(r.tctrl[DBS_MODE_LSB+:2]);
    assign align = dbs_align_t'(r.tctrl[DBS_ALIGN_LSB+:2]);
    assign trace_active = armed && r.tctrl[DBS_TEN_BIT] && !secured;

    always_comb begin
        next_r = r;
        // Read data stands for one cycle only
        next_r.rdata = DBS_RDATA_RST;
        if (bus_rd) begin
            unique case (bus_addr)
                DBS_STATUS_OFS: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[DBS_FULL_BIT] = r.full;
                    next_r.rdata[DBS_SEQ_LSB+:3] = seq_flags;
                end
                DBS_TRACE_CTRL_OFS: next_r.rdata = r.tctrl;
                default: next_r.rdata = DBS_RDATA_RST;
            endcase
        end
        // Status offset takes no write at all
        if (bus_wr && bus_addr == DBS_TRACE_CTRL_OFS) begin
            if (!secured && !armed) begin
                next_r.tctrl[DBS_RSV_BIT] = bus_wdata[DBS_RSV_BIT];
                next_r.tctrl[DBS_TEN_BIT] = bus_wdata[DBS_TEN_BIT];
            end
            if (!armed) begin
                next_r.tctrl[5:0] = bus_wdata[5:0];
            end
        end
        // Line count since arming; arm restarts it
        if (arm_write) begin
            next_r.lines = 7'h00;
            next_r.full = 1'b0;
            next_r.have_last = 1'b0;
        end
        if (line_written && (arm_write || r.lines != DBS_BUF_LINES)) begin
            next_r.lines = (arm_write ? 7'h00 : r.lines) + 7'h01;
        end
        // A line arriving with the clear still sets the flag when the old count is 63 or more
        if (line_written && r.lines >= DBS_BUF_LINES - 7'h01) begin
            next_r.full = 1'b1;
        end
        next_r.valid = r.full ? DBS_BUF_LINES : entry_count;
        // Store requests
        next_r.s_cof = 1'b0;
        next_r.s_acc = 1'b0;
        next_r.s_pc = 1'b0;
        if (trace_active) begin
            unique case (mode)
                DBS_MODE_NORMAL: begin
                    if (cof_valid) begin
                        next_r.s_cof = 1'b1;
                        next_r.s_addr = cof_addr;
                    end
                end
                DBS_MODE_LOOP: begin
                    if (cof_valid && !(r.have_last && cof_addr == r.last_cof)) begin
                        next_r.s_cof = 1'b1;
                        next_r.s_addr = cof_addr;
                        next_r.last_cof = cof_addr;
                        next_r.have_last = 1'b1;
                    end
                end
                DBS_MODE_DETAIL: begin
                    if (acc_valid && acc_in_range) begin
                        next_r.s_acc = 1'b1;
                        next_r.s_addr = acc_addr;
                    end
                end
                DBS_MODE_PURE_PC: begin
                    if (pc_valid) begin
                        next_r.s_pc = 1'b1;
                        next_r.s_addr = pc_addr;
                    end
                end
            endcase
        end
        // Trigger placement; reserved code falls back to end
        next_r.a_end = (align == DBS_ALIGN_END) || (align == DBS_ALIGN_RSV);
        next_r.a_begin = (align == DBS_ALIGN_BEGIN);
        next_r.a_mid = (align == DBS_ALIGN_MID);
        // Enabled comparators keep driving cmp_c_trig and cmp_d_trig
        next_r.c_trig = cmp_c_match && cmp_c_enable;
        next_r.d_trig = cmp_d_match && cmp_d_enable;
        // System reset spares the full flag, line count, valid count, store and loop addresses and placement flags
        if (sys_reset) begin
            next_r.tctrl = DBS_TRACE_CTRL_RST;
            next_r.rdata = DBS_RDATA_RST;
            next_r.s_cof = 1'b0;
            next_r.s_acc = 1'b0;
            next_r.s_pc = 1'b0;
            next_r.have_last = 1'b0;
            next_r.c_trig = 1'b0;
            next_r.d_trig = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata = r.rdata;
    assign valid_lines = r.valid;
    assign store_cof = r.s_cof;
    assign store_acc = r.s_acc;
    assign store_pc = r.s_pc;
    assign store_addr = r.s_addr;
    assign trig_align_end = r.a_end;
    assign trig_align_begin = r.a_begin;
    assign trig_align_mid = r.a_mid;
    assign cmp_c_trig = r.c_trig;
    assign cmp_d_trig = r.d_trig;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dbs_cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    full_set_a: assert property (
        line_written && r.lines == DBS_BUF_LINES - 7'h01 |=> r.full)
        else $error("full flag not set at 64 lines");
    full_valid_a: assert property (
        r.full |=> valid_lines == DBS_BUF_LINES)
        else $error("valid lines not 64 while full");
    arm_clear_a: assert property (
        arm_write && !line_written |=> !r.full)
        else $error("arm write did not clear full flag");
    sysrst_keep_a: assert property (
        sys_reset && !arm_write && !line_written |=> $stable(r.full))
        else $error("system reset changed full flag");
    seq_arm_a: assert property (
        arm_write && !trig_end && !sys_reset |=> seq_flags == 3'b001)
        else $error("arming did not force state1");
    seq_trig_a: assert property (
        trig_end |=> seq_flags == 3'b000)
        else $error("trigger end did not return to state0");
    seq_hold_a: assert property (
        !armed && !arm_write && !trig_end && !sys_reset |=> $stable(seq_flags))
        else $error("flags moved while disarmed");
    seq_legal_a: assert property (
        seq_flags <= 3'b100)
        else $error("reserved sequencer code");
    ctrl_lock_a: assert property (
        armed && !sys_reset |=> $stable(r.tctrl))
        else $error("trace control changed while armed");
    secure_ten_a: assert property (
        secured && !r.tctrl[DBS_TEN_BIT] && !sys_reset |=> !r.tctrl[DBS_TEN_BIT])
        else $error("trace enable set while secured");
    secure_store_a: assert property (
        secured |=> !(store_cof || store_acc || store_pc))
        else $error("store while secured");
    normal_store_a: assert property (
        trace_active && mode == DBS_MODE_NORMAL && cof_valid && !sys_reset
        |=> store_cof && store_addr == $past(cof_addr))
        else $error("normal mode missed change of flow");
    loop_drop_a: assert property (
        trace_active && mode == DBS_MODE_LOOP && r.have_last && cof_addr == r.last_cof
        |=> !store_cof)
        else $error("redundant entry stored in loop mode");
    status_ro_a: assert property (
        bus_wr && bus_addr == DBS_STATUS_OFS && !line_written && !arm_write
        |=> $stable(r.full))
        else $error("status write changed full flag");
    status_read_a: assert property (
        bus_rd && bus_addr == DBS_STATUS_OFS && !sys_reset
        |=> bus_rdata == {$past(r.full), 4'h0, $past(seq_flags)})
        else $error("status read data wrong");
    seq_goto_a: assert property (
        armed && seq_goto_valid && seq_goto_code <= 3'b100 && !arm_write && !trig_end && !sys_reset
        |=> seq_flags == $past(seq_goto_code))
        else $error("sequencer missed new state");
    ctrl_write_a: assert property (
        bus_wr && bus_addr == DBS_TRACE_CTRL_OFS && !secured && !armed && !sys_reset
        |=> r.tctrl == $past(bus_wdata))
        else $error("trace control write lost");
    valid_count_a: assert property (
        resetn && !r.full |=> valid_lines == $past(entry_count))
        else $error("valid lines not entry count");
    trace_off_a: assert property (
        !r.tctrl[DBS_TEN_BIT] |=> !(store_cof || store_acc || store_pc))
        else $error("store with trace disabled");
    range_drop_a: assert property (
        mode == DBS_MODE_DETAIL && !acc_in_range |=> !store_acc)
        else $error("out of range access stored");
    comp_trig_a: assert property (
        cmp_c_match && cmp_c_enable && !sys_reset |=> cmp_c_trig)
        else $error("enabled comparator gave no trigger");
    detail_store_a: assert property (
        trace_active && mode == DBS_MODE_DETAIL && acc_valid && acc_in_range && !sys_reset
        |=> store_acc && store_addr == $past(acc_addr))
        else $error("detail mode missed access");
    align_begin_a: assert property (
        align == DBS_ALIGN_BEGIN |=> trig_align_begin && !trig_align_end && !trig_align_mid)
        else $error("begin placement not decoded");
    pure_pc_a: assert property (
        trace_active && mode == DBS_MODE_PURE_PC && pc_valid && !sys_reset
        |=> store_pc && store_addr == $past(pc_addr))
        else $error("pure PC mode missed sample");
endmodule
`default_nettype wire

// File: sim/dbs_core_model.sv
`default_nettype none
module dbs_core_model #(
    parameter int AW = 23
) (
    // Clock
    input wire logic core_clk,
    // Core activity
    output logic cof_valid,
    output logic [AW-1:0] cof_addr,
    output logic acc_valid,
    output logic [AW-1:0] acc_addr,
    output logic pc_valid,
    output logic [AW-1:0] pc_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cof_valid = 1'b0;
        acc_valid = 1'b0;
        pc_valid = 1'b0;
        cof_addr = '0;
        acc_addr = '0;
        pc_addr = '0;
    end
    // ------------------------------------------------------------
    // One event: 0 change of flow, 1 access, 2 PC sample
    // ------------------------------------------------------------
    task automatic emit(input logic [1:0] k, input logic [AW-1:0] a);
        @(posedge core_clk);
        cof_valid <= (k == 2'h0);
        acc_valid <= (k == 2'h1);
        pc_valid <= (k == 2'h2);
        cof_addr <= a;
        acc_addr <= a;
        pc_addr <= a;
        @(posedge core_clk);
        cof_valid <= 1'b0;
        acc_valid <= 1'b0;
        pc_valid <= 1'b0;
        // Stale address scrambled once the event is gone
        cof_addr <= ~a;
        acc_addr <= ~a;
        pc_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top
    import dbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, resetn = 1'b0, sys_reset = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
    logic bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0;
    logic armed = 1'b0, arm_write = 1'b0, secured = 1'b0, trig_end = 1'b0;
    logic seq_goto_valid = 1'b0;
    logic [2:0] seq_goto_code = 3'h0;
    logic [22:0] cmp_c_addr = 23'h000100, cmp_d_addr = 23'h000200;
    logic cmp_c_match = 1'b0, cmp_d_match = 1'b0, cmp_c_enable = 1'b0;
    logic cmp_d_enable = 1'b0, cmp_c_trig, cmp_d_trig;
    logic cof_valid, acc_valid, pc_valid, store_cof, store_acc, store_pc;
    logic [22:0] cof_addr, acc_addr, pc_addr, store_addr, a, b;
    logic line_written = 1'b0;
    logic [6:0] entry_count = 7'h00, valid_lines;
    logic trig_align_end, trig_align_begin, trig_align_mid;
    int miscompares = 0, cmp_count = 0;
    logic [7:0] rd_q[$];
    logic [25:0] st_q[$];
    logic [25:0] st_got;
    assign st_got = {store_pc, store_acc, store_cof, store_addr};
    logic [31:0] lfsr = 32'hAAC2FCB5;
    logic [2:0] al[4] = '{3'b001, 3'b100, 3'b010, 3'b001};
    logic [2:0] gs[4] = '{3'h2, 3'h3, 3'h5, 3'h4};
    logic [2:0] ge[4] = '{3'h2, 3'h3, 3'h3, 3'h4};
    // Range, keep, address
    logic [25:0] dt[7] = '{{3'b001, 23'h7FFFFF}, {3'b011, 23'h000000},
        {3'b010, 23'h000201}, {3'b101, 23'h000100}, {3'b100, 23'h0000FF},
        {3'b111, 23'h000200}, {3'b110, 23'h000050}};

    dbs_status_trace #(.ADDR_W(23)) DUT (.core_clk(core_clk), .resetn(resetn),
        .sys_reset(sys_reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .armed(armed),
        .arm_write(arm_write), .secured(secured), .trig_end(trig_end),
        .seq_goto_valid(seq_goto_valid), .seq_goto_code(seq_goto_code),
        .cmp_c_addr(cmp_c_addr), .cmp_d_addr(cmp_d_addr), .cmp_c_match(cmp_c_match),
        .cmp_d_match(cmp_d_match), .cmp_c_enable(cmp_c_enable),
        .cmp_d_enable(cmp_d_enable), .cmp_c_trig(cmp_c_trig), .cmp_d_trig(cmp_d_trig),
        .cof_valid(cof_valid), .cof_addr(cof_addr), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .pc_valid(pc_valid), .pc_addr(pc_addr),
        .line_written(line_written), .entry_count(entry_count),
        .valid_lines(valid_lines), .store_cof(store_cof), .store_acc(store_acc),
        .store_pc(store_pc), .store_addr(store_addr), .trig_align_end(trig_align_end),
        .trig_align_begin(trig_align_begin), .trig_align_mid(trig_align_mid));

    dbs_core_model #(.AW(23)) CORE (.core_clk(core_clk), .cof_valid(cof_valid),
        .cof_addr(cof_addr), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .pc_valid(pc_valid), .pc_addr(pc_addr));

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [22:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[22:0];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= ad;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= ad;
        @(posedge core_clk);
        bus_rd <= 1'b0;
    endtask
    task automatic arm();
        @(posedge core_clk);
        armed <= 1'b1;
        arm_write <= 1'b1;
        entry_count <= 7'h00;
        @(posedge core_clk);
        arm_write <= 1'b0;
    endtask
    task automatic goto(input logic [2:0] c);
        @(posedge core_clk);
        seq_goto_valid <= 1'b1;
        seq_goto_code <= c;
        @(posedge core_clk);
        seq_goto_valid <= 1'b0;
    endtask
    task automatic cmp(input logic ce, input logic de);
        @(posedge core_clk);
        cmp_c_match <= 1'b1;
        cmp_d_match <= 1'b1;
        cmp_c_enable <= ce;
        cmp_d_enable <= de;
        @(posedge core_clk);
        cmp_c_match <= 1'b0;
        cmp_d_match <= 1'b0;
        @(negedge core_clk);
        check({cmp_c_trig, cmp_d_trig}, {ce, de});
    endtask
    task automatic lines(input int n);
        repeat (n) begin
            @(posedge core_clk);
            line_written <= 1'b1;
            entry_count <= entry_count + 7'h01;
        end
        @(posedge core_clk);
        line_written <= 1'b0;
    endtask
    task automatic sess(input logic [7:0] c);
        @(posedge core_clk);
        armed <= 1'b0;
        wr(8'h22, c);
        arm();
    endtask
    task automatic ev(input int k, input logic [22:0] ad, input logic keep);
        if (keep) st_q.push_back({3'b001 << k, ad});
        CORE.emit(k[1:0], ad);
    endtask
    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge core_clk) rd_d <= bus_rd;
    always @(negedge core_clk) begin
        if (rd_d) begin
            if (rd_q.size() > 0) check(bus_rdata, rd_q.pop_front());
            else check(bus_rdata, 32'hFFFFFFFF);
        end
        if (store_cof | store_acc | store_pc) begin
            if (st_q.size() > 0) check(st_got, st_q.pop_front());
            else check(st_got, 32'hFFFFFFFF);
        end
    end
    initial begin
        #100us;
        miscompares++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h22, 8'h58 | i[7:0]);
            rd(8'h22, 8'h58 | i[7:0]);
            @(negedge core_clk);
            check({trig_align_begin, trig_align_mid, trig_align_end}, al[i]);
        end
        wr(8'h22, 8'h00);
        secured <= 1'b1;
        wr(8'h22, 8'h7F);
        rd(8'h22, 8'h3F);
        secured <= 1'b0;
        wr(8'h22, 8'h40);
        arm();
        wr(8'h22, 8'h2A);
        rd(8'h22, 8'h40);
        rd(8'h21, 8'h01);
        for (int i = 0; i < 4; i++) begin
            goto(gs[i]);
            rd(8'h21, {5'h00, ge[i]});
        end
        armed <= 1'b0;
        goto(3'h2);
        rd(8'h21, 8'h04);
        arm();
        goto(3'h3);
        trig_end <= 1'b1;
        armed <= 1'b0;
        @(posedge core_clk);
        trig_end <= 1'b0;
        rd(8'h21, 8'h00);
        cmp(1'b1, 1'b0);
        cmp(1'b0, 1'b1);
        a = rnd();
        b = a ^ 23'h000001;
        sess(8'h40);
        ev(0, a, 1'b1);
        ev(1, a, 1'b0);
        ev(2, a, 1'b0);
        sess(8'h44);
        ev(0, a, 1'b1);
        ev(0, a, 1'b0);
        ev(0, b, 1'b1);
        for (int i = 0; i < 7; i++) begin
            sess(8'h48 | {2'b00, dt[i][25:24], 4'h0});
            ev(1, dt[i][22:0], dt[i][23]);
        end
        ev(0, a, 1'b0);
        sess(8'h4C);
        ev(2, b, 1'b1);
        ev(0, b, 1'b0);
        secured <= 1'b1;
        ev(2, a, 1'b0);
        secured <= 1'b0;
        sess(8'h00);
        ev(0, a, 1'b0);
        lines(63);
        rd(8'h21, 8'h01);
        @(negedge core_clk);
        check(valid_lines, 7'h3F);
        lines(1);
        entry_count <= 7'h05;
        rd(8'h21, 8'h81);
        @(negedge core_clk);
        check(valid_lines, 7'h40);
        @(posedge core_clk);
        sys_reset <= 1'b1;
        armed <= 1'b0;
        @(posedge core_clk);
        sys_reset <= 1'b0;
        rd(8'h21, 8'h80);
        arm();
        rd(8'h21, 8'h01);
        lines(64);
        resetn <= 1'b0;
        armed <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'h21, 8'h00);
        repeat (3) @(posedge core_clk);
        check(rd_q.size() + st_q.size(), 0);
        print_verdict();
    end
endmodule
`default_nettype wire
